// *** src/scr_pkg.sv ***
// constants, field layouts and carrier types of the port configuration register bank
//
// Contract
// - subsystem header: id 0xD, loadable next pointer
// - subsystem vendor and subsystem codes, loadable
// - pointer bits 7:2 select register number
// - pointer bits 11:8 give extended register number
// - window read returns selected register value
// - window write updates selected register normally
// - window acts only on enabled byte lanes
// - window pointing at itself: zero, discard
// - side port window access: zero, no effect
// - error header: id 1, version 1, pointer 0x200
// - obsolete bit sticky clear-by-one, reserved zero
// - link protocol error sets bit 4
// - surprise down bit 5, zero unless capable
// - poisoned packet sets bit 12
// - flow control error sets bit 13
// - completion timeout bit 14 always zero
// - completer abort bit 15 always zero
// - unexpected completion sets bit 16
// - receiver overflow sets bit 17
// - malformed packet sets bit 18
// - end-to-end crc error sets bit 19
// - unsupported request sets bit 20
package scr_pkg;

  // register byte offsets in configuration space
  localparam logic [11:0] OFS_SUBSYS_CAP   = 12'h0F0;
  localparam logic [11:0] OFS_SUBSYS_IDENT = 12'h0F4;
  localparam logic [11:0] OFS_IND_PTR      = 12'h0F8;
  localparam logic [11:0] OFS_IND_WIN      = 12'h0FC;
  localparam logic [11:0] OFS_ERR_HDR      = 12'h100;
  localparam logic [11:0] OFS_UE_FLAGS     = 12'h104;

  // constant fields and reset values
  localparam logic [7:0]  SUBSYS_CAP_ID    = 8'h0D;
  localparam logic [7:0]  SUBSYS_NEXT_RST  = 8'h00;
  localparam logic [31:0] SUBSYS_IDENT_RST = 32'h0000_0000;
  localparam logic [9:0]  IND_PTR_RST      = 10'h000;
  localparam logic [15:0] ERR_CAP_ID       = 16'h0001;
  localparam logic [3:0]  ERR_CAP_VER      = 4'h1;
  localparam logic [11:0] ERR_NEXT_RST     = 12'h200;
  localparam logic [31:0] UE_RST           = 32'h0000_0000;

  // writable field masks
  localparam logic [31:0] SUBSYS_CAP_WMASK = 32'h0000_FF00;
  localparam logic [31:0] IND_PTR_WMASK    = 32'h0000_0FFC;
  localparam logic [31:0] ERR_HDR_WMASK    = 32'hFFF0_0000;
  localparam logic [31:0] UE_WMASK         = 32'h001F_3031;

  // uncorrectable error flag positions
  localparam int UE_OBSOLETE  = 0;
  localparam int UE_LINK_PROT = 4;
  localparam int UE_SURPRISE  = 5;
  localparam int UE_POISONED  = 12;
  localparam int UE_FLOW_CTRL = 13;
  localparam int UE_COMPL_TO  = 14;
  localparam int UE_CPL_ABORT = 15;
  localparam int UE_UNEXP_CPL = 16;
  localparam int UE_RX_OVF    = 17;
  localparam int UE_MALFORMED = 18;
  localparam int UE_E2E_CRC   = 19;
  localparam int UE_UNSUP_REQ = 20;

  // one configuration access, from a config request or the side port
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        smbus;
    logic [11:0] addr;
    logic [3:0]  byteEn;
    logic [31:0] wdata;
  } scr_req_t;

  // answer, one cycle after the request
  typedef struct packed {
    logic        ack;
    logic        hit;
    logic [31:0] rdata;
  } scr_rsp_t;

  // one-cycle error detector pulses
  typedef struct packed {
    logic linkProtocolError;
    logic surpriseDown;
    logic poisoned;
    logic flowControlError;
    logic unexpectedCompletion;
    logic receiverOverflow;
    logic malformed;
    logic e2eCrcError;
    logic unsupportedRequest;
  } scr_err_evt_t;

endpackage

// *** src/scr_cfg_regs.sv ***
// per-port subsystem id, indirect window and uncorrectable error status registers
`timescale 1ns/1ns
module scr_cfg_regs (
  // clock and resets
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  input  wire logic                  hotRst_b,
  // configuration access
  input  wire scr_pkg::scr_req_t     req,
  output      scr_pkg::scr_rsp_t     rsp,
  // error detectors and link capability
  input  wire scr_pkg::scr_err_evt_t errEvt,
  input  wire logic                  surpriseDownReportingCapable
);

  // stored fields
  logic [7:0]  capNext;       // subsystem header next pointer
  logic [31:0] ident;         // vendor code low, subsystem code high
  logic [9:0]  ptrIdx;        // pointer bits 11:2
  logic [11:0] errNext;       // error header next pointer
  logic [31:0] ue;            // uncorrectable error flags
  logic [31:0] rdata;         // registered read data
  logic        ack;           // registered answer strobe
  logic        hit;           // registered mapped flag

  // next values
  logic [7:0]  next_capNext;
  logic [31:0] next_ident;
  logic [9:0]  next_ptrIdx;
  logic [11:0] next_errNext;
  logic [31:0] next_ue;
  logic [31:0] next_rdata;
  logic        next_ack;
  logic        next_hit;

  // access decode
  logic [11:0] directAddr;    // dword-aligned request address
  logic [11:0] tgtAddr;       // register actually acted on
  logic        tgtLive;       // access reaches a register at all
  logic        tgtMapped;     // target is one of ours
  logic [31:0] laneMask;      // byte enables spread to bits
  logic [31:0] tgtValue;      // current value of target
  logic [31:0] setVec;        // hardware set requests
  logic [31:0] clrVec;        // software clear requests
  logic        doWrite;       // write reaches target
  logic [31:0] wrMerged;      // written word before field extraction

  // merge written lanes into writable fields only
  function automatic logic [31:0] mergeWr(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [31:0] lanes, input logic [31:0] wmask);
    logic [31:0] m;
    m = lanes & wmask;
    return (old & ~m) | (wd & m);
  endfunction

  // address and window resolution
  always_comb begin
    directAddr = {req.addr[11:2], 2'b00};
    laneMask   = {{8{req.byteEn[3]}}, {8{req.byteEn[2]}}, {8{req.byteEn[1]}}, {8{req.byteEn[0]}}};
    tgtAddr    = directAddr;
    tgtLive    = req.valid;
    if (directAddr == scr_pkg::OFS_IND_WIN) begin
      // window: redirect to the register the pointer names
      tgtAddr = {ptrIdx, 2'b00};
      if (req.smbus) begin
        tgtLive = 1'b0;
      end else if (tgtAddr == scr_pkg::OFS_IND_WIN) begin
        tgtLive = 1'b0;
      end
    end
    doWrite = tgtLive && req.write;
  end

  // current value of the target register
  always_comb begin
    tgtMapped = 1'b1;
    unique case (tgtAddr)
      scr_pkg::OFS_SUBSYS_CAP: begin
        tgtValue = {16'h0000, capNext, scr_pkg::SUBSYS_CAP_ID};
      end
      scr_pkg::OFS_SUBSYS_IDENT: begin
        tgtValue = ident;
      end
      scr_pkg::OFS_IND_PTR: begin
        tgtValue = {20'h00000, ptrIdx, 2'b00};
      end
      scr_pkg::OFS_ERR_HDR: begin
        tgtValue = {errNext, scr_pkg::ERR_CAP_VER, scr_pkg::ERR_CAP_ID};
      end
      scr_pkg::OFS_UE_FLAGS: begin
        tgtValue = ue;
      end
      default: begin
        // other configuration space lives elsewhere; reads zero here
        tgtValue  = 32'h0000_0000;
        tgtMapped = 1'b0;
      end
    endcase
  end

  // answer path: data masked to enabled lanes, zero when nothing is reached
  always_comb begin
    next_ack   = req.valid;
    next_hit   = tgtLive && tgtMapped;
    next_rdata = 32'h0000_0000;
    if (tgtLive && !req.write) begin
      next_rdata = tgtValue & laneMask;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ack   <= 1'b0;
      hit   <= 1'b0;
      rdata <= 32'h0000_0000;
    end else begin
      ack   <= next_ack;
      hit   <= next_hit;
      rdata <= next_rdata;
    end
  end

  assign rsp.ack   = ack;
  assign rsp.hit   = hit;
  assign rsp.rdata = rdata;

  // loadable and plain read-write fields; fields are cut from the merged word on purpose
  always_comb begin
    wrMerged     = 32'h0000_0000;
    next_capNext = capNext;
    next_ident   = ident;
    next_ptrIdx  = ptrIdx;
    next_errNext = errNext;
    if (doWrite) begin
      unique case (tgtAddr)
        scr_pkg::OFS_SUBSYS_CAP: begin
          wrMerged     = mergeWr({16'h0000, capNext, 8'h00}, req.wdata, laneMask,
                                 scr_pkg::SUBSYS_CAP_WMASK);
          next_capNext = wrMerged[15:8];
        end
        scr_pkg::OFS_SUBSYS_IDENT: begin
          next_ident = mergeWr(ident, req.wdata, laneMask, 32'hFFFF_FFFF);
        end
        scr_pkg::OFS_IND_PTR: begin
          wrMerged    = mergeWr({20'h00000, ptrIdx, 2'b00}, req.wdata, laneMask,
                                scr_pkg::IND_PTR_WMASK);
          next_ptrIdx = wrMerged[11:2];
        end
        scr_pkg::OFS_ERR_HDR: begin
          wrMerged     = mergeWr({errNext, 20'h00000}, req.wdata, laneMask,
                                 scr_pkg::ERR_HDR_WMASK);
          next_errNext = wrMerged[31:20];
        end
        default: begin
          // flags handled below; unmapped writes are dropped
        end
      endcase
    end
  end

  // non-sticky fields return to defaults on any reset
  always_ff @(posedge clk) begin
    if (!rst_b || !hotRst_b) begin
      capNext <= scr_pkg::SUBSYS_NEXT_RST;
      ident   <= scr_pkg::SUBSYS_IDENT_RST;
      ptrIdx  <= scr_pkg::IND_PTR_RST;
      errNext <= scr_pkg::ERR_NEXT_RST;
    end else begin
      capNext <= next_capNext;
      ident   <= next_ident;
      ptrIdx  <= next_ptrIdx;
      errNext <= next_errNext;
    end
  end

  // sticky error flags: detector set beats a clear in the same cycle
  always_comb begin
    setVec = 32'h0000_0000;
    setVec[scr_pkg::UE_LINK_PROT] = errEvt.linkProtocolError;
    setVec[scr_pkg::UE_SURPRISE]  = errEvt.surpriseDown;
    setVec[scr_pkg::UE_POISONED]  = errEvt.poisoned;
    setVec[scr_pkg::UE_FLOW_CTRL] = errEvt.flowControlError;
    setVec[scr_pkg::UE_UNEXP_CPL] = errEvt.unexpectedCompletion;
    setVec[scr_pkg::UE_RX_OVF]    = errEvt.receiverOverflow;
    setVec[scr_pkg::UE_MALFORMED] = errEvt.malformed;
    setVec[scr_pkg::UE_E2E_CRC]   = errEvt.e2eCrcError;
    setVec[scr_pkg::UE_UNSUP_REQ] = errEvt.unsupportedRequest;
    clrVec = 32'h0000_0000;
    if (doWrite && tgtAddr == scr_pkg::OFS_UE_FLAGS) begin
      // only ones clear; zeros and read-only bits are left alone
      clrVec = req.wdata & laneMask & scr_pkg::UE_WMASK;
    end
    next_ue = ((ue & ~clrVec) | setVec) & scr_pkg::UE_WMASK;
    if (!surpriseDownReportingCapable) begin
      // without the reporting capability this flag cannot show
      next_ue[scr_pkg::UE_SURPRISE] = 1'b0;
    end
  end

  // only the power-on reset clears the sticky flags
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ue <= scr_pkg::UE_RST;
    end else begin
      ue <= next_ue;
    end
  end

  // ---------------- assertions ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // plain full-lane read at an address
  sequence s_rd(logic [11:0] a);
    req.valid && !req.write && !req.smbus && req.byteEn == 4'hF && req.addr == a;
  endsequence

  // full-lane config write to an address
  sequence s_wr(logic [11:0] a);
    req.valid && req.write && !req.smbus && req.byteEn == 4'hF && req.addr == a;
  endsequence

  property p_subsysHdr;
    s_rd(scr_pkg::OFS_SUBSYS_CAP) |=> rsp.ack && rsp.rdata[7:0] == 8'h0D && rsp.rdata[31:16] == 16'h0000;
  endproperty
  a_subsysHdr: assert property (p_subsysHdr) else $error("subsystem header wrong");

  property p_identWrite;
    s_wr(scr_pkg::OFS_SUBSYS_IDENT) ##1 (hotRst_b && !req.valid) ##1 s_rd(scr_pkg::OFS_SUBSYS_IDENT)
      |=> rsp.rdata == $past(req.wdata, 3);
  endproperty
  a_identWrite: assert property (p_identWrite) else $error("subsystem ident not stored");

  property p_ptrReserved;
    s_rd(scr_pkg::OFS_IND_PTR) |=> rsp.rdata[1:0] == 2'b00 && rsp.rdata[31:12] == 20'h00000;
  endproperty
  a_ptrReserved: assert property (p_ptrReserved) else $error("pointer reserved bits set");

  property p_windowRead;
    (s_rd(scr_pkg::OFS_IND_WIN) and ##0 (ptrIdx == 10'h041)) |=> rsp.rdata == $past(ue);
  endproperty
  a_windowRead: assert property (p_windowRead) else $error("window read mismatch");

  property p_windowSelf;
    (req.valid && !req.write && req.addr == scr_pkg::OFS_IND_WIN && ptrIdx == 10'h03F)
      |=> rsp.ack && rsp.rdata == 32'h0000_0000;
  endproperty
  a_windowSelf: assert property (p_windowSelf) else $error("self window read nonzero");

  property p_sideWindow;
    (req.valid && req.smbus && req.addr[11:2] == 10'h03F) |=> rsp.rdata == 32'h0000_0000 && !rsp.hit;
  endproperty
  a_sideWindow: assert property (p_sideWindow) else $error("side port window acted");

  property p_errHdr;
    s_rd(scr_pkg::OFS_ERR_HDR) |=> rsp.rdata[19:0] == 20'h10001;
  endproperty
  a_errHdr: assert property (p_errHdr) else $error("error header wrong");

  property p_linkSet;
    errEvt.linkProtocolError |=> ue[4] [*2];
  endproperty
  a_linkSet: assert property (p_linkSet) else $error("link protocol flag not held");

  property p_surpriseGate;
    !surpriseDownReportingCapable |=> !ue[5];
  endproperty
  a_surpriseGate: assert property (p_surpriseGate) else $error("surprise flag without capability");

  property p_hardZero;
    ue[15:14] == 2'b00 && ue[11:6] == 6'h00 && ue[3:1] == 3'h0 && ue[31:21] == 11'h000;
  endproperty
  a_hardZero: assert property (p_hardZero) else $error("read-only flag bits set");

  property p_clearOne;
    (s_wr(scr_pkg::OFS_UE_FLAGS) and ##0 (req.wdata[12] && !errEvt.poisoned)) |=> !ue[12];
  endproperty
  a_clearOne: assert property (p_clearOne) else $error("write one did not clear");

  property p_zeroKeeps;
    (s_wr(scr_pkg::OFS_UE_FLAGS) and ##0 (!req.wdata[13] && ue[13])) |=> ue[13];
  endproperty
  a_zeroKeeps: assert property (p_zeroKeeps) else $error("write zero changed flag");

  property p_warmKeeps;
    (!hotRst_b && ue[16]) |=> ue[16] && capNext == 8'h00;
  endproperty
  a_warmKeeps: assert property (p_warmKeeps) else $error("warm reset lost sticky flag");

  property p_setWins;
    (s_wr(scr_pkg::OFS_UE_FLAGS) and ##0 errEvt.receiverOverflow) |=> ue[17];
  endproperty
  a_setWins: assert property (p_setWins) else $error("clear beat set");

endmodule

// *** tb/tb_scr_cfg_regs.sv ***
// self-checking bench for the port configuration register bank
`timescale 1ns/1ns
module tb_scr_cfg_regs;
  // expectation noted by the driver, consumed by the monitor
  typedef struct packed {
    logic        chkHit;
    logic        hit;
    logic [31:0] rdata;
  } scr_exp_t;

  logic                  clk;                          // 50 MHz bench clock
  logic                  rst_b;                        // cold reset
  logic                  hotRst_b;                     // warm reset
  logic                  surpriseDownReportingCapable; // link capability bit
  scr_pkg::scr_req_t     req;                          // access request
  scr_pkg::scr_rsp_t     rsp;                          // registered answer
  scr_pkg::scr_err_evt_t errEvt;                       // detector pulses
  scr_exp_t              expQ[$];                      // pending expectations
  scr_exp_t              expNow;                       // note being compared
  int                    err_count;                    // mismatches
  int                    checks;                       // comparisons made
  int                    seed;                         // random seed
  logic [31:0]           ident;                        // subsystem ident mirror
  logic [31:0]           v;                            // scratch random data
  int                    pos[9];                       // flag bit per event, lsb first

  scr_cfg_regs i_dut (
    .clk                          (clk),
    .rst_b                        (rst_b),
    .hotRst_b                     (hotRst_b),
    .req                          (req),
    .rsp                          (rsp),
    .errEvt                       (errEvt),
    .surpriseDownReportingCapable (surpriseDownReportingCapable)
  );

  // clock generation
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // byte lanes to bit mask
  function automatic logic [31:0] lanes(input logic [3:0] be);
    lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // one access: request held for one cycle, then released at the next falling edge
  task automatic acc(input logic wr, input logic sm, input logic [11:0] a, input logic [3:0] be,
                     input logic [31:0] wd, input logic [31:0] er, input logic eh, input logic ch);
    @(negedge clk);
    req = '{valid: 1'b1, write: wr, smbus: sm, addr: a, byteEn: be, wdata: wd};
    expQ.push_back('{ch, eh, (wr ? 32'h0000_0000 : (er & lanes(be)))});
    @(negedge clk);
    req.valid = 1'b0;
  endtask

  // direct read with hit expected as given
  task automatic rdReg(input logic [11:0] a, input logic [3:0] be, input logic [31:0] er, input logic eh);
    acc(1'b0, 1'b0, a, be, 32'h0000_0000, er, eh, 1'b1);
  endtask

  // write, hit not judged since window writes may differ
  task automatic wrReg(input logic [11:0] a, input logic [3:0] be, input logic [31:0] wd);
    acc(1'b1, 1'b0, a, be, wd, 32'h0000_0000, 1'b0, 1'b0);
  endtask

  // one detector pulse of one cycle
  task automatic pulse(input logic [8:0] m);
    @(negedge clk);
    errEvt = scr_pkg::scr_err_evt_t'(m);
    @(negedge clk);
    errEvt = scr_pkg::scr_err_evt_t'(9'h000);
  endtask

  // verdict and end of run
  task automatic stop_test;
    if (err_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // monitor: answers arrive one cycle after the request, settled by the falling edge
  always @(negedge clk) begin
    if (rsp.ack === 1'b1) begin
      if (expQ.size() == 0) begin
        err_count++;
        $display("Error ack expected 0 seen 1");
      end else begin
        expNow = expQ.pop_front();
        checks++;
        if (rsp.rdata !== expNow.rdata) begin
          err_count++;
          $display("Error rdata expected %h seen %h", expNow.rdata, rsp.rdata);
        end
        if (expNow.chkHit === 1'b1 && rsp.hit !== expNow.hit) begin
          err_count++;
          $display("Error hit expected %b seen %b", expNow.hit, rsp.hit);
        end
      end
    end
  end

  // watchdog: the sequence needs well under 20000 cycles
  initial begin
    #(20 * 20000);
    err_count++;
    stop_test();
  end

  // main sequence
  initial begin
    rst_b = 1'b0;
    hotRst_b = 1'b1;
    surpriseDownReportingCapable = 1'b1;
    req = '0;
    errEvt = '0;
    err_count = 0;
    checks = 0;
    seed = 66;
    ident = 32'h0000_0000;
    pos = '{20, 19, 18, 17, 16, 13, 12, 5, 4};
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    // reset values and constant fields
    rdReg(12'h0F0, 4'hF, 32'h0000_000D, 1'b1);
    rdReg(12'h0F4, 4'hF, 32'h0000_0000, 1'b1);
    rdReg(12'h0F8, 4'hF, 32'h0000_0000, 1'b1);
    rdReg(12'h100, 4'hF, 32'h2001_0001, 1'b1);
    rdReg(12'h104, 4'hF, 32'h0000_0000, 1'b1);
    rdReg(12'h0E0, 4'hF, 32'h0000_0000, 1'b0);
    // all ones reach only the writable fields
    wrReg(12'h0F0, 4'hF, 32'hFFFF_FFFF);
    rdReg(12'h0F0, 4'hF, 32'h0000_FF0D, 1'b1);
    wrReg(12'h0F8, 4'hF, 32'hFFFF_FFFF);
    rdReg(12'h0F8, 4'hF, 32'h0000_0FFC, 1'b1);
    wrReg(12'h100, 4'hF, 32'hFFFF_FFFF);
    rdReg(12'h100, 4'hF, 32'hFFF1_0001, 1'b1);
    wrReg(12'h104, 4'hF, 32'hFFFF_FFFF);
    rdReg(12'h104, 4'hF, 32'h0000_0000, 1'b1);
    // full-lane random write, then single-lane writes of random data, then a masked read
    v = $random(seed);
    wrReg(12'h0F4, 4'hF, v);
    ident = v;
    rdReg(12'h0F4, 4'hF, ident, 1'b1);
    for (int k = 0; k < 4; k++) begin
      v = $random(seed);
      wrReg(12'h0F4, 4'(1 << k), v);
      ident = (ident & ~lanes(4'(1 << k))) | (v & lanes(4'(1 << k)));
      rdReg(12'h0F4, 4'hF, ident, 1'b1);
    end
    rdReg(12'h0F4, 4'h6, ident, 1'b1);
    // window onto the ident register, written on upper lanes, read back on lower lanes
    wrReg(12'h0F8, 4'hF, 32'h0000_00F4);
    v = $random(seed);
    wrReg(12'h0FC, 4'hC, v);
    ident = (ident & ~lanes(4'hC)) | (v & lanes(4'hC));
    rdReg(12'h0F4, 4'hF, ident, 1'b1);
    acc(1'b0, 1'b0, 12'h0FC, 4'h3, 32'h0, ident, 1'b0, 1'b0);
    // side port sees zero and cannot write through the window
    acc(1'b0, 1'b1, 12'h0FC, 4'hF, 32'h0, 32'h0, 1'b0, 1'b1);
    acc(1'b1, 1'b1, 12'h0FC, 4'hF, ~ident, 32'h0, 1'b0, 1'b0);
    rdReg(12'h0F4, 4'hF, ident, 1'b1);
    // window aimed at itself
    wrReg(12'h0F8, 4'hF, 32'h0000_00FC);
    acc(1'b0, 1'b0, 12'h0FC, 4'hF, 32'h0, 32'h0, 1'b0, 1'b1);
    wrReg(12'h0FC, 4'hF, 32'hFFFF_FFFF);
    rdReg(12'h0F8, 4'hF, 32'h0000_00FC, 1'b1);
    // each detector alone, seen through the extended window, then cleared
    wrReg(12'h0F8, 4'hF, 32'h0000_0104);
    for (int i = 0; i < 9; i++) begin
      pulse(9'h001 << i);
      acc(1'b0, 1'b0, 12'h0FC, 4'hF, 32'h0, 32'h1 << pos[i], 1'b0, 1'b0);
      wrReg(12'h104, 4'hF, 32'h0000_0000);
      rdReg(12'h104, 4'hF, 32'h1 << pos[i], 1'b1);
      wrReg(12'h104, 4'hF, 32'h1 << pos[i]);
      rdReg(12'h104, 4'hF, 32'h0000_0000, 1'b1);
    end
    // overflow event and its clear in one cycle: the set must win
    fork
      pulse(9'h008);
      wrReg(12'h104, 4'hF, 32'h0002_0000);
    join
    rdReg(12'h104, 4'hF, 32'h0002_0000, 1'b1);
    // surprise down held off when not capable
    surpriseDownReportingCapable = 1'b0;
    pulse(9'h1FF);
    rdReg(12'h104, 4'hF, 32'h001F_3010, 1'b1);
    // warm reset keeps flags, returns loadable fields to their reset values
    @(negedge clk);
    hotRst_b = 1'b0;
    @(negedge clk);
    hotRst_b = 1'b1;
    rdReg(12'h104, 4'hF, 32'h001F_3010, 1'b1);
    rdReg(12'h0F4, 4'hF, 32'h0000_0000, 1'b1);
    rdReg(12'h100, 4'hF, 32'h2001_0001, 1'b1);
    // cold reset clears flags
    @(negedge clk);
    rst_b = 1'b0;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    rdReg(12'h104, 4'hF, 32'h0000_0000, 1'b1);
    repeat (3) @(negedge clk);
    if (expQ.size() != 0) begin
      err_count++;
      $display("Error pending answers expected 0 seen %0d", expQ.size());
    end
    stop_test();
  end
endmodule
